// >>> hw/ifc_defs.vh
`ifndef IFC_DEFS_VH
`define IFC_DEFS_VH

// ----------------------------------------------------------------
// configuration word field positions
// ----------------------------------------------------------------
`define IFC_CFG_WIDTH        16
`define IFC_CFG_RESET        16'h0000
`define IFC_BIT_USE_PROX     11
`define IFC_BIT_USE_ENC      10
`define IFC_BIT_HOME_INDEX   9
`define IFC_FN3_MSB          8
`define IFC_FN3_LSB          6
`define IFC_FN2_MSB          5
`define IFC_FN2_LSB          3
`define IFC_FN1_MSB          2
`define IFC_FN1_LSB          0
`define IFC_FN_WIDTH         3
`define IFC_NUM_INPUTS       3
`define IFC_NUM_ENC_PINS     3

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define IFC_SETTLE_CYCLES    3'h5

// ----------------------------------------------------------------
// input function codes
// ----------------------------------------------------------------
`define IFC_FN_GENERAL       3'h0
`define IFC_FN_CW_LIMIT      3'h1
`define IFC_FN_CCW_LIMIT     3'h2
`define IFC_FN_START_CAPTURE 3'h3
`define IFC_FN_STOP_CAPTURE  3'h4
`define IFC_FN_ESTOP         3'h5
`define IFC_FN_HOME          3'h6
`define IFC_FN_RESERVED      3'h7

`endif

// >>> hw/ifc_pin_sync.v
`timescale 1ns/100ps
// ----------------------------------------------------------------
// three-stage input synchroniser; output moves once stages 2 and 3 agree
// ----------------------------------------------------------------
module ifc_pin_sync (
    input  wire clock_i,
    input  wire rst_n_i,
    input  wire pin_i,
    output reg  level_o
);
    reg s1_r;
    reg s2_r;
    reg s3_r;

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_r    <= 1'b0;
            s2_r    <= 1'b0;
            s3_r    <= 1'b0;
            level_o <= 1'b0;
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_o <= s3_r;
            end
        end
    end
endmodule // ifc_pin_sync

// >>> hw/ifc_input_function_config.v
`timescale 1ns/100ps
`include "ifc_defs.vh"
module ifc_input_function_config (
    input  wire        clock_i,
    input  wire        rst_n_i,
    input  wire [15:0] cfg_word_i,
    input  wire        cfg_write_i,
    input  wire [2:0]  input_polarity_i,
    input  wire [2:0]  input_pin_i,
    input  wire        net_prox_flag_i,
    input  wire        homing_active_i,
    input  wire        index_move_pending_i,
    input  wire        jog_or_reg_running_i,
    input  wire        enc_a_i,
    input  wire        enc_b_i,
    input  wire        enc_index_i,
    output reg  [2:0]  input_state_o,
    output reg         cfg_valid_o,
    output reg         cfg_error_o,
    output reg         encoder_enable_o,
    output reg         home_to_index_o,
    output reg         cw_limit_o,
    output reg         ccw_limit_o,
    output reg         start_index_o,
    output reg         ctrl_stop_o,
    output reg         estop_o,
    output reg         home_ref_o,
    output reg         home_prox_o,
    output reg         capture_o,
    output reg         enc_a_o,
    output reg         enc_b_o,
    output reg         enc_index_o
);

    // ----------------------------------------------------------------
    // configuration register
    // ----------------------------------------------------------------
    reg  [15:0] cfg_r;
    wire        cfg_bad;
    wire        cfg_take;
    wire        cfg_reject;
    wire [2:0]  fn_code [0:2];

    function [2:0] field_of;
        input [15:0] w;
        input integer idx;
        begin
            case (idx)
                0:       field_of = w[`IFC_FN1_MSB:`IFC_FN1_LSB];
                1:       field_of = w[`IFC_FN2_MSB:`IFC_FN2_LSB];
                default: field_of = w[`IFC_FN3_MSB:`IFC_FN3_LSB];
            endcase
        end
    endfunction

    function fn_reserved;
        input [2:0] code;
        begin
            fn_reserved = (code == `IFC_FN_RESERVED);
        end
    endfunction

    // reserved code on any input, or index homing without encoder
    assign cfg_bad = fn_reserved(field_of(cfg_word_i, 0)) ||
                     fn_reserved(field_of(cfg_word_i, 1)) ||
                     fn_reserved(field_of(cfg_word_i, 2)) ||
                     (cfg_word_i[`IFC_BIT_HOME_INDEX] && !cfg_word_i[`IFC_BIT_USE_ENC]);

    assign cfg_take   = cfg_write_i & ~cfg_bad;
    assign cfg_reject = cfg_write_i & cfg_bad;

    // rejected writes keep the previous good word so motion stays safe
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_r <= `IFC_CFG_RESET;
        end else if (cfg_take) begin
            cfg_r <= cfg_word_i;
        end
    end

    // valid only ever rises; error follows the outcome of the last write
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_valid_o <= 1'b0;
            cfg_error_o <= 1'b0;
        end else if (cfg_reject) begin
            cfg_error_o <= 1'b1;
        end else if (cfg_take) begin
            cfg_valid_o <= 1'b1;
            cfg_error_o <= 1'b0;
        end
    end

    wire use_prox   = cfg_r[`IFC_BIT_USE_PROX];
    wire use_enc    = cfg_r[`IFC_BIT_USE_ENC];
    wire home_index = cfg_r[`IFC_BIT_HOME_INDEX] & use_enc;

    // ----------------------------------------------------------------
    // edge qualification after reset
    // ----------------------------------------------------------------
    // sync flops wake at zero, so an active-low input would look like
    // a fresh activation; edges count only once the pin path settled
    reg  [2:0] settle_cnt_r;
    wire       settled = (settle_cnt_r == `IFC_SETTLE_CYCLES);

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            settle_cnt_r <= 3'h0;
        end else if (!settled) begin
            settle_cnt_r <= settle_cnt_r + 3'h1;
        end
    end

    // ----------------------------------------------------------------
    // per-input sync, polarity and edge detection
    // ----------------------------------------------------------------
    wire [2:0] pin_lvl;
    wire [2:0] act;
    reg  [2:0] act_r;
    wire [2:0] rise;
    wire [2:0] edge_any;

    genvar g;
    generate
        for (g = 0; g < `IFC_NUM_INPUTS; g = g + 1) begin : g_in
            ifc_pin_sync u_sync (
                .clock_i (clock_i),
                .rst_n_i (rst_n_i),
                .pin_i   (input_pin_i[g]),
                .level_o (pin_lvl[g])
            );
            // polarity 1: active when current flows; 0: active when open
            // a polarity change while running looks like a real edge
            assign act[g]      = ~(pin_lvl[g] ^ input_polarity_i[g]);
            assign rise[g]     = settled & act[g] & ~act_r[g];
            assign edge_any[g] = settled & (act[g] ^ act_r[g]);
            assign fn_code[g]  = field_of(cfg_r, g);
        end
    endgenerate

    // ----------------------------------------------------------------
    // encoder pins
    // ----------------------------------------------------------------
    // synchronised and gated by use_enc here; counting and position latching sit downstream
    wire [2:0] enc_raw;
    wire [2:0] enc_lvl;

    assign enc_raw = {enc_index_i, enc_b_i, enc_a_i};

    generate
        for (g = 0; g < `IFC_NUM_ENC_PINS; g = g + 1) begin : g_enc
            ifc_pin_sync u_sync (
                .clock_i (clock_i),
                .rst_n_i (rst_n_i),
                .pin_i   (enc_raw[g]),
                .level_o (enc_lvl[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // function decode
    // ----------------------------------------------------------------
    reg cw_nxt;
    reg ccw_nxt;
    reg start_nxt;
    reg stop_nxt;
    reg estop_nxt;
    reg home_nxt;
    reg prox_nxt;
    reg cap_nxt;
    integer i;

    // inputs sharing one function are ORed; a reserved code never
    // reaches cfg_r, so the default branch stays idle
    always @* begin
        cw_nxt    = 1'b0;
        ccw_nxt   = 1'b0;
        start_nxt = 1'b0;
        stop_nxt  = 1'b0;
        estop_nxt = 1'b0;
        home_nxt  = 1'b0;
        prox_nxt  = homing_active_i & use_prox & net_prox_flag_i;
        cap_nxt   = 1'b0;
        for (i = 0; i < `IFC_NUM_INPUTS; i = i + 1) begin
            case (fn_code[i])
                `IFC_FN_GENERAL: begin
                    // reported only, no motion effect
                end
                `IFC_FN_CW_LIMIT: begin
                    cw_nxt = cw_nxt | act[i];
                end
                `IFC_FN_CCW_LIMIT: begin
                    ccw_nxt = ccw_nxt | act[i];
                end
                `IFC_FN_START_CAPTURE: begin
                    start_nxt = start_nxt | (rise[i] & index_move_pending_i);
                    cap_nxt   = cap_nxt | (edge_any[i] & use_enc);
                end
                `IFC_FN_STOP_CAPTURE: begin
                    stop_nxt = stop_nxt | (rise[i] & jog_or_reg_running_i);
                    cap_nxt  = cap_nxt | (rise[i] & jog_or_reg_running_i & use_enc);
                end
                `IFC_FN_ESTOP: begin
                    estop_nxt = estop_nxt | rise[i];
                end
                `IFC_FN_HOME: begin
                    if (home_index) begin
                        prox_nxt = prox_nxt | act[i];
                    end else begin
                        home_nxt = home_nxt | act[i];
                    end
                end
                default: begin
                    // reserved code never loaded
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // input state and edge history
    // ----------------------------------------------------------------
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            act_r         <= 3'h0;
            input_state_o <= 3'h0;
        end else begin
            act_r         <= act;
            input_state_o <= act;
        end
    end

    // ----------------------------------------------------------------
    // configuration levels
    // ----------------------------------------------------------------
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            encoder_enable_o <= 1'b0;
            home_to_index_o  <= 1'b0;
        end else begin
            encoder_enable_o <= use_enc;
            home_to_index_o  <= home_index;
        end
    end

    // ----------------------------------------------------------------
    // motion outputs; held off until a good word is in force
    // ----------------------------------------------------------------
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cw_limit_o    <= 1'b0;
            ccw_limit_o   <= 1'b0;
            start_index_o <= 1'b0;
            ctrl_stop_o   <= 1'b0;
            estop_o       <= 1'b0;
            home_ref_o    <= 1'b0;
            home_prox_o   <= 1'b0;
            capture_o     <= 1'b0;
        end else begin
            cw_limit_o    <= cfg_valid_o & cw_nxt;
            ccw_limit_o   <= cfg_valid_o & ccw_nxt;
            start_index_o <= cfg_valid_o & start_nxt;
            ctrl_stop_o   <= cfg_valid_o & stop_nxt;
            estop_o       <= cfg_valid_o & estop_nxt;
            home_ref_o    <= cfg_valid_o & home_nxt;
            home_prox_o   <= cfg_valid_o & prox_nxt;
            capture_o     <= cfg_valid_o & cap_nxt;
        end
    end

    // ----------------------------------------------------------------
    // encoder pins; gated off when unused
    // ----------------------------------------------------------------
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            enc_a_o     <= 1'b0;
            enc_b_o     <= 1'b0;
            enc_index_o <= 1'b0;
        end else begin
            enc_a_o     <= use_enc & enc_lvl[0];
            enc_b_o     <= use_enc & enc_lvl[1];
            enc_index_o <= use_enc & enc_lvl[2];
        end
    end

endmodule // ifc_input_function_config

// >>> verif/ifc_host_model.sv
`timescale 1ns/100ps
module ifc_host_model (
    input  wire logic        clock_i,
    output logic      [15:0] cfg_word_o,
    output logic             cfg_write_o
);
    initial begin
        cfg_word_o = 16'h0000;
        cfg_write_o = 1'b0;
    end
    // ----------------------------------------------------------------
    // single word write; counts-per-turn word lives outside this block
    // ----------------------------------------------------------------
    task write_cfg(input logic [15:0] w);
        @(posedge clock_i);
        #1 cfg_word_o = w;
        cfg_write_o = 1'b1;
        @(posedge clock_i);
        #1 cfg_write_o = 1'b0;
        cfg_word_o = ~w;  // released bus must not look like the last word
    endtask
endmodule  // ifc_host_model

// >>> verif/ifc_input_function_config_checker.sv
`timescale 1ns/100ps
module ifc_input_function_config_checker (
    input wire        clock_i,
    input wire        rst_n_i,
    input wire [15:0] cfg_word_i,
    input wire        cfg_write_i,
    input wire        index_move_pending_i,
    input wire        jog_or_reg_running_i,
    input wire        cfg_valid_o,
    input wire        cfg_error_o,
    input wire        encoder_enable_o,
    input wire        home_to_index_o,
    input wire        cw_limit_o,
    input wire        start_index_o,
    input wire        ctrl_stop_o,
    input wire        estop_o,
    input wire        capture_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // index homing without encoder is as bad as a reserved code
    wire bad_w  = (&cfg_word_i[8:6]) | (&cfg_word_i[5:3]) | (&cfg_word_i[2:0]) | (cfg_word_i[9] & ~cfg_word_i[10]);
    wire motion = cw_limit_o | start_index_o | ctrl_stop_o | estop_o;

    a_bad_refused: assert property (cfg_write_i && bad_w |=> cfg_error_o && cfg_valid_o == $past(cfg_valid_o))
        else $error("bad word not refused");
    a_good_taken: assert property (cfg_write_i && !bad_w |=> cfg_valid_o && !cfg_error_o)
        else $error("good word not taken");
    a_enc_follows: assert property (cfg_write_i && !bad_w ##1 !cfg_write_i |=> encoder_enable_o == $past(cfg_word_i[10], 2))
        else $error("encoder enable not from word");
    a_index_gate: assert property (home_to_index_o |-> encoder_enable_o)
        else $error("index homing without encoder");
    a_idle_unconf: assert property (!cfg_valid_o |-> !motion)
        else $error("motion output while unconfigured");
    a_estop_pulse: assert property (estop_o |=> !estop_o)
        else $error("emergency stop not a pulse");
    a_start_pending: assert property (start_index_o |-> $past(index_move_pending_i))
        else $error("start without pending move");
    a_stop_running: assert property (ctrl_stop_o |-> $past(jog_or_reg_running_i))
        else $error("stop without running move");
    a_capture_enc: assert property (capture_o |-> encoder_enable_o)
        else $error("capture with encoder off");
endmodule  // ifc_input_function_config_checker

bind ifc_input_function_config ifc_input_function_config_checker chk (.clock_i, .rst_n_i, .cfg_word_i, .cfg_write_i,
    .index_move_pending_i, .jog_or_reg_running_i, .cfg_valid_o, .cfg_error_o, .encoder_enable_o, .home_to_index_o,
    .cw_limit_o, .start_index_o, .ctrl_stop_o, .estop_o, .capture_o);

// >>> verif/tb.sv
`timescale 1ns/100ps
module tb;
    logic        clock_i = 1'b0, rst_n_i = 1'b0;
    logic [2:0]  input_polarity_i = 3'h7, input_pin_i = 3'h0;
    logic        net_prox_flag_i = 1'b0, homing_active_i = 1'b0, index_move_pending_i = 1'b1;
    logic        jog_or_reg_running_i = 1'b1, enc_a_i = 1'b0, enc_b_i = 1'b0, enc_index_i = 1'b0;
    wire  [15:0] cfg_word_i;
    wire  [2:0]  input_state_o;
    wire         cfg_write_i, cfg_valid_o, cfg_error_o, encoder_enable_o, home_to_index_o, cw_limit_o, ccw_limit_o;
    wire         start_index_o, ctrl_stop_o, estop_o, home_ref_o, home_prox_o, capture_o, enc_a_o, enc_b_o, enc_index_o;
    int          error_cnt = 0, compares = 0;
    logic [6:0]  seen = 7'h00;
    // {cw, ccw, start, stop, estop, home, capture} per function code
    logic [6:0]  fn_exp [7] = '{7'h00, 7'h40, 7'h20, 7'h11, 7'h09, 7'h04, 7'h02};

    always #4 clock_i = ~clock_i;
    always @(posedge clock_i) seen <= seen | {cw_limit_o, ccw_limit_o, start_index_o, ctrl_stop_o, estop_o, home_ref_o, capture_o};

    ifc_host_model host (.clock_i(clock_i), .cfg_word_o(cfg_word_i), .cfg_write_o(cfg_write_i));
    ifc_input_function_config uut (.clock_i, .rst_n_i, .cfg_word_i, .cfg_write_i, .input_polarity_i, .input_pin_i,
        .net_prox_flag_i, .homing_active_i, .index_move_pending_i, .jog_or_reg_running_i, .enc_a_i, .enc_b_i,
        .enc_index_i, .input_state_o, .cfg_valid_o, .cfg_error_o, .encoder_enable_o, .home_to_index_o, .cw_limit_o,
        .ccw_limit_o, .start_index_o, .ctrl_stop_o, .estop_o, .home_ref_o, .home_prox_o, .capture_o, .enc_a_o,
        .enc_b_o, .enc_index_o);

    task finish_test;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    // drive an input to its active or inactive level, wait for the report
    task set_in(input int k, input logic a);
        int i;
        input_pin_i[k] = ~(a ^ input_polarity_i[k]);
        for (i = 0; i < 20 && input_state_o[k] !== a; i++) step(1);
        if (input_state_o[k] !== a) begin
            error_cnt++;
            $display("wrong value at %0t: input state stuck", $time);
            finish_test();
        end
    endtask
    task run_fn(input int k, input logic [2:0] code);
        host.write_cfg(16'h0400 | ({13'h0, code} << (3 * k)));
        seen = 7'h00;
        set_in(k, 1'b1);
        step(2);
        check(seen, fn_exp[code]);
        seen = 7'h00;
        set_in(k, 1'b0);
        step(2);
        check({seen[4:2], seen[0]}, {3'h0, code == 3'h3});
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_refuse;
        int k;
        check({cfg_valid_o, cfg_error_o, encoder_enable_o}, 0);
        for (k = 0; k < 3; k++) begin
            host.write_cfg(16'h0007 << (3 * k));
            check({cfg_valid_o, cfg_error_o}, 2'h1);
        end
        host.write_cfg(16'h0200);
        check({cfg_valid_o, cfg_error_o}, 2'h1);
        host.write_cfg(16'h0600);
        step(1);
        check({cfg_valid_o, cfg_error_o, home_to_index_o}, 3'h5);
        host.write_cfg(16'h01c0);
        check({cfg_valid_o, cfg_error_o, encoder_enable_o}, 3'h7);
    endtask
    task t_functions;
        int k, c;
        for (k = 0; k < 3; k++)
            for (c = 0; c < 7; c++) run_fn(k, c[2:0]);
    endtask
    task t_polarity;
        input_polarity_i = 3'h5;
        input_pin_i[1] = 1'b1;
        step(8);
        run_fn(1, 3'h5);
        input_polarity_i = 3'h7;
        input_pin_i[1] = 1'b0;
        step(8);
    endtask
    task t_encoder;
        host.write_cfg(16'h0000);
        {enc_a_i, enc_b_i, enc_index_i} = 3'h7;
        step(8);
        check({enc_a_o, enc_b_o, enc_index_o}, 3'h0);
        host.write_cfg(16'h0400);
        step(8);
        check({enc_a_o, enc_b_o, enc_index_o}, 3'h7);
        {enc_a_i, enc_b_i, enc_index_i} = 3'h0;
    endtask
    task t_homing;
        host.write_cfg(16'h0e06);
        homing_active_i = 1'b1;
        set_in(0, 1'b1);
        step(2);
        check({home_prox_o, home_ref_o}, 2'h2);
        set_in(0, 1'b0);
        net_prox_flag_i = 1'b1;
        step(3);
        check(home_prox_o, 1'b1);
        host.write_cfg(16'h0606);
        step(3);
        check(home_prox_o, 1'b0);
        {homing_active_i, net_prox_flag_i} = 2'h0;
    endtask
    // start needs a pending move, stop a running one; capture needs the encoder
    task t_gating;
        {index_move_pending_i, jog_or_reg_running_i} = 2'h0;
        host.write_cfg(16'h0423);
        seen = 7'h00;
        set_in(0, 1'b1);
        set_in(1, 1'b1);
        step(2);
        check(seen, 7'h01);
        {index_move_pending_i, jog_or_reg_running_i} = 2'h3;
        set_in(0, 1'b0);
        set_in(1, 1'b0);
        host.write_cfg(16'h0023);
        seen = 7'h00;
        set_in(0, 1'b1);
        set_in(1, 1'b1);
        step(2);
        check(seen, 7'h18);
        set_in(0, 1'b0);
        set_in(1, 1'b0);
    endtask
    // reset in mid-run drops the stored word; a fresh write is taken again
    task t_reset;
        rst_n_i = 1'b0;
        step(1);
        check({cfg_valid_o, cfg_error_o, encoder_enable_o, home_to_index_o, input_state_o}, 7'h00);
        rst_n_i = 1'b1;
        host.write_cfg(16'h0400);
        step(1);
        check({cfg_valid_o, cfg_error_o, encoder_enable_o}, 3'h5);
    endtask

    initial begin
        repeat (5) @(posedge clock_i);
        #1 rst_n_i = 1'b1;
        t_refuse();
        t_functions();
        t_gating();
        t_polarity();
        t_encoder();
        t_homing();
        t_reset();
        finish_test();
    end
endmodule  // tb
